// ===== boost_pfc_regs.svh
/*
 * Timing counts and reset values for the boost switch controller.
 * Assumes a 40 ns system clock period and a 12-bit compensation word.
 */
`ifndef BOOST_PFC_REGS_SVH
`define BOOST_PFC_REGS_SVH

// System clock period in ns (25 MHz)
`define CLK_PERIOD_NS 40
// Restart pulse period in us, and the same period in clock cycles
`define WD_PERIOD_US 400
`define WD_CYCLES ((`WD_PERIOD_US * 1000) / `CLK_PERIOD_NS)

// Compensation word: reset value and saturation limits, in cycles of on-time
`define COMP_RESET 12'h064
`define COMP_MIN 12'h001
`define COMP_MAX 12'hfff
// Extra on-time near the line zero crossings, in cycles
`define MOD_CYCLES 12'h010
// Compensation step per switching cycle for high and low loop gain
`define STEP_HI 12'h004
`define STEP_LO 12'h001

`endif

// ===== boost_pfc_pkg.sv
/*
 * Types shared by the boost switch controller.
 * Assumes the including design also reads boost_pfc_regs.svh for numbers.
 */
package boost_pfc_pkg;

  // Operating mode reported by the ballast section
  typedef enum logic [1:0] {
    BM_PREHEAT = 2'h0,
    BM_IGNITION = 2'h1,
    BM_RUN = 2'h2,
    BM_FAULT = 2'h3
  } ballast_mode_t;

  // Switching state, one-hot
  typedef enum logic [4:0] {
    ST_HALT = 5'h01,
    ST_WAIT_RISE = 5'h02,
    ST_WAIT_FALL = 5'h04,
    ST_ON = 5'h08,
    ST_OVP = 5'h10
  } sw_state_t;

endpackage

// ===== restart_timer.sv
/*
 * Restart pulse timer: counts clock-enabled cycles and gives a pulse each period.
 * Assumes PERIOD is at least 2 and that the caller clears it on valid edges.
 */
`timescale 1ns/1ps

module restart_timer #(
  parameter int PERIOD = 10000
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Control and event
  input wire logic clear,
  output logic expire
);

  localparam int CW = $clog2(PERIOD);

  logic [CW-1:0] cnt_reg;

  // Expiry in the last cycle of the period
  assign expire = (cnt_reg == CW'(PERIOD - 1));

  // Period counter, restarted by clear or by its own expiry
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (ce) begin
      if (clear || expire) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule

// ===== ontime_gen.sv
/*
 * On-time generator: latches a cycle count at start and flags its last cycle.
 * Assumes target is at least one and start comes only while idle or finishing.
 */
`timescale 1ns/1ps

module ontime_gen #(
  parameter int TW = 13
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Control
  input wire logic start,
  input wire logic kill,
  input wire logic [TW-1:0] target,
  // Status
  output logic done,
  output logic [TW-1:0] target_out
);

  logic active_reg;
  logic [TW-1:0] cnt_reg;
  logic [TW-1:0] target_reg;

  // Last cycle of the programmed on interval
  assign done = active_reg && (cnt_reg == target_reg - 1'b1);
  assign target_out = target_reg;

  // Interval counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_reg <= 1'b0;
      cnt_reg <= '0;
      target_reg <= '0;
    end else if (ce) begin
      if (start) begin
        active_reg <= 1'b1;
        cnt_reg <= '0;
        target_reg <= target;
      end else if (kill || done) begin
        active_reg <= 1'b0;
        cnt_reg <= '0;
      end else if (active_reg) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule

// ===== boost_pfc_ctrl.sv
/*
 * Switch-timing control of a critical-conduction boost stage: zero-cross driven
 * turn-on, compensation-programmed on-time, restart pulses, bus protection.
 * Assumes every comparator input is already synchronous to SYS_CLK and that
 * the ballast section supplies its operating mode.
 */
`timescale 1ns/1ps
`include "boost_pfc_regs.svh"

module boost_pfc_ctrl
  import boost_pfc_pkg::*;
#(
  parameter int COMP_W = 12,
  parameter int WD_CYCLES = `WD_CYCLES
) (
  // Clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  // Comparator results
  input wire logic ZERO_CROSS_INPUT,
  input wire logic BUS_OVER_CMP,
  input wire logic BUS_BELOW_REG_CMP,
  input wire logic BUS_UNDER_CMP,
  input wire logic LINE_NEAR_ZERO,
  // Ballast section state
  input wire ballast_mode_t BALLAST_MODE,
  // Gate and loop outputs
  output logic BOOST_GATE_OUT,
  output logic GAIN_SEL_HIGH,
  output logic SUPPLY_DISCHARGE,
  output logic [COMP_W-1:0] COMP_VALUE
);

  localparam int TW = COMP_W + 1;

  sw_state_t state_reg;
  sw_state_t state_next;
  logic zx_prev_reg;
  logic uv_latch_reg;
  logic gain_high_reg;
  logic [COMP_W-1:0] comp_reg;
  logic [COMP_W-1:0] comp_next;
  logic [COMP_W-1:0] step;
  logic zx_rise;
  logic zx_fall;
  logic valid_fall;
  logic disable_now;
  logic wd_clear;
  logic wd_expire;
  logic on_start;
  logic on_done;
  logic [TW-1:0] on_target;
  logic [TW-1:0] on_target_held;
  logic [TW-1:0] on_len_reg;

  // ****************************************
  // Input edges and disable conditions
  // ****************************************

  // Previous zero-cross level for edge detection
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      zx_prev_reg <= 1'b0;
    end else if (CLK_EN) begin
      zx_prev_reg <= ZERO_CROSS_INPUT;
    end
  end

  // Edges of the hysteretic zero-cross comparator
  assign zx_rise = ZERO_CROSS_INPUT && !zx_prev_reg;
  assign zx_fall = !ZERO_CROSS_INPUT && zx_prev_reg;
  assign valid_fall = (state_reg == ST_WAIT_FALL) && zx_fall;
  assign disable_now = uv_latch_reg || BUS_UNDER_CMP || (BALLAST_MODE == BM_FAULT);

  // Under-voltage latch, cleared only by reset
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      uv_latch_reg <= 1'b0;
    end else if (CLK_EN && BUS_UNDER_CMP) begin
      uv_latch_reg <= 1'b1;
    end
  end

  assign SUPPLY_DISCHARGE = uv_latch_reg;

  // ****************************************
  // Switching state machine
  // ****************************************

  // Next state, protection first
  always_comb begin
    state_next = state_reg;
    if (disable_now) begin
      state_next = ST_HALT;
    end else if (BUS_OVER_CMP) begin
      state_next = ST_OVP;
    end else begin
      case (state_reg)
        ST_HALT: begin
          state_next = ST_WAIT_RISE;
        end
        ST_WAIT_RISE: begin
          if (zx_rise) begin
            state_next = ST_WAIT_FALL;
          end else if (wd_expire) begin
            state_next = ST_ON;
          end
        end
        ST_WAIT_FALL: begin
          if (zx_fall || wd_expire) begin
            state_next = ST_ON;
          end
        end
        ST_ON: begin
          if (on_done) begin
            state_next = ST_WAIT_RISE;
          end
        end
        ST_OVP: begin
          if (BUS_BELOW_REG_CMP) begin
            state_next = ST_ON;
          end
        end
        default: begin
          state_next = ST_HALT;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_reg <= ST_HALT;
    end else if (CLK_EN) begin
      state_reg <= state_next;
    end
  end

  assign BOOST_GATE_OUT = (state_reg == ST_ON);
  assign on_start = (state_next == ST_ON) && (state_reg != ST_ON);

  // ****************************************
  // Restart timer and on-time
  // ****************************************

  // Held clear while stopped or after a valid zero-cross fall
  assign wd_clear = valid_fall || (state_reg == ST_HALT) || (state_reg == ST_OVP);

  restart_timer #(
    .PERIOD(WD_CYCLES)
  ) u_restart (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .ce(CLK_EN),
    .clear(wd_clear),
    .expire(wd_expire)
  );

  // On-time from compensation plus line modulation
  assign on_target = {1'b0, comp_reg} + (LINE_NEAR_ZERO ? TW'(`MOD_CYCLES) : TW'(0));

  ontime_gen #(
    .TW(TW)
  ) u_ontime (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .ce(CLK_EN),
    .start(on_start && CLK_EN),
    .kill(state_next != ST_ON),
    .target(on_target),
    .done(on_done),
    .target_out(on_target_held)
  );

  // ****************************************
  // Regulation loop
  // ****************************************

  // Loop gain follows the ballast mode
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      gain_high_reg <= 1'b1;
    end else if (CLK_EN) begin
      gain_high_reg <= (BALLAST_MODE != BM_RUN);
    end
  end

  assign GAIN_SEL_HIGH = gain_high_reg;
  assign step = gain_high_reg ? COMP_W'(`STEP_HI) : COMP_W'(`STEP_LO);

  // Saturating compensation step, direction from the bus comparator
  always_comb begin
    if (BUS_BELOW_REG_CMP) begin
      comp_next = (comp_reg > `COMP_MAX - step) ? `COMP_MAX : comp_reg + step;
    end else begin
      comp_next = (comp_reg < `COMP_MIN + step) ? `COMP_MIN : comp_reg - step;
    end
  end

  // Compensation updated once per switching cycle
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      comp_reg <= COMP_W'(`COMP_RESET);
    end else if (CLK_EN && on_start) begin
      comp_reg <= comp_next;
    end
  end

  assign COMP_VALUE = comp_reg;

  // ****************************************
  // Checks
  // ****************************************

  // Length of the current gate pulse, for checking only
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      on_len_reg <= '0;
    end else if (CLK_EN) begin
      on_len_reg <= BOOST_GATE_OUT ? on_len_reg + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  property p_ov_off;
    CLK_EN && BUS_OVER_CMP |=> !BOOST_GATE_OUT;
  endproperty
  a_ov_off: assert property (p_ov_off)
    else $error("gate not low under over-voltage");

  property p_uv_latch;
    CLK_EN && BUS_UNDER_CMP |=> SUPPLY_DISCHARGE && !BOOST_GATE_OUT ##1 SUPPLY_DISCHARGE;
  endproperty
  a_uv_latch: assert property (p_uv_latch)
    else $error("under-voltage not latched");

  property p_turn_on_cause;
    $rose(BOOST_GATE_OUT) |-> $past(valid_fall) || $past(wd_expire) || $past(state_reg == ST_OVP);
  endproperty
  a_turn_on_cause: assert property (p_turn_on_cause)
    else $error("gate turned on without zero-cross, restart or recovery");

  property p_rise_starts_off;
    CLK_EN && (state_reg == ST_WAIT_RISE) && zx_rise && !disable_now && !BUS_OVER_CMP
      |=> (state_reg == ST_WAIT_FALL) && !BOOST_GATE_OUT;
  endproperty
  a_rise_starts_off: assert property (p_rise_starts_off)
    else $error("rising zero-cross did not start off interval");

  property p_fall_turns_on;
    CLK_EN && valid_fall && !disable_now && !BUS_OVER_CMP |=> BOOST_GATE_OUT;
  endproperty
  a_fall_turns_on: assert property (p_fall_turns_on)
    else $error("falling zero-cross did not turn gate on");

  property p_on_length;
    CLK_EN && BOOST_GATE_OUT && !disable_now && !BUS_OVER_CMP && on_done
      |-> on_len_reg + 1'b1 == on_target_held;
  endproperty
  a_on_length: assert property (p_on_length)
    else $error("on interval length differs from programmed on-time");

  property p_fall_needs_rise;
    CLK_EN && (state_reg == ST_WAIT_RISE) && zx_fall && !wd_expire |=> !BOOST_GATE_OUT;
  endproperty
  a_fall_needs_rise: assert property (p_fall_needs_rise)
    else $error("fall without preceding rise turned gate on");

  property p_restart_fires;
    CLK_EN && (state_reg == ST_WAIT_RISE) && wd_expire && !zx_rise && !disable_now
      && !BUS_OVER_CMP |=> BOOST_GATE_OUT;
  endproperty
  a_restart_fires: assert property (p_restart_fires)
    else $error("restart pulse missing");

  property p_ovp_recover;
    CLK_EN && (state_reg == ST_OVP) && !BUS_OVER_CMP && BUS_BELOW_REG_CMP && !disable_now
      |=> BOOST_GATE_OUT;
  endproperty
  a_ovp_recover: assert property (p_ovp_recover)
    else $error("no recovery pulse after over-voltage");

  property p_gain_run;
    CLK_EN && (BALLAST_MODE == BM_RUN) |=> !GAIN_SEL_HIGH;
  endproperty
  a_gain_run: assert property (p_gain_run)
    else $error("gain select not low in run");

  property p_loop_dir;
    CLK_EN && on_start && !BUS_BELOW_REG_CMP && (comp_reg > `COMP_MIN + step)
      |=> comp_reg == $past(comp_reg) - $past(step);
  endproperty
  a_loop_dir: assert property (p_loop_dir)
    else $error("on-time not shortened for high bus");

  c_normal: cover property (valid_fall && CLK_EN ##1 BOOST_GATE_OUT);
  c_restart: cover property ((state_reg == ST_WAIT_RISE) && wd_expire && CLK_EN);
  c_ovp: cover property ((state_reg == ST_OVP) ##1 BOOST_GATE_OUT);
  c_uv: cover property ($rose(SUPPLY_DISCHARGE));

endmodule

// ===== boost_stage_model.sv
/*
 * Far-side model: boost transistor, inductor winding and zero-cross comparator.
 * Assumes the gate is registered on the rising clock edge and that the bench
 * has seeded the random generator.
 */
`timescale 1ns/1ps

module boost_stage_model (
  // Clock and gate
  input wire logic clk,
  input wire logic gate,
  // Test control: winding never rings back
  input wire logic stuck,
  // Winding comparator result
  output logic zx
);
  // After each turn-off with stuck low the winding swings up, then drops when the inductor is empty
  initial begin
    zx = 1'b0;
    forever begin
      // Wait for a real turn-off, not the unknown-to-low step at start-up
      wait (gate === 1'b1);
      wait (gate === 1'b0);
      if (!stuck) begin
        repeat (1 + $urandom % 4) @(negedge clk);
        zx = 1'b1;
        repeat (3 + $urandom % 18) @(negedge clk);
        zx = 1'b0;
      end
    end
  end
endmodule

// ===== boost_pfc_ctrl_tb.sv
/*
 * Self-checking bench of the boost switch controller.
 * Assumes the stage model answers each turn-off while stuck is low; restart period shortened.
 */
`timescale 1ns/1ps
`include "boost_pfc_regs.svh"

module boost_pfc_ctrl_tb;
  import boost_pfc_pkg::*;
  localparam int WD = 200;
  logic SYS_CLK = 1'b0;
  logic RST_N, CLK_EN, ZERO_CROSS_INPUT, BUS_OVER_CMP, BUS_BELOW_REG_CMP;
  logic BUS_UNDER_CMP, LINE_NEAR_ZERO, BOOST_GATE_OUT, GAIN_SEL_HIGH;
  logic SUPPLY_DISCHARGE, stuck, cut, gate_d, line_d, below_d, gain_m, gain_d;
  logic [11:0] COMP_VALUE, comp_m, step_m;
  ballast_mode_t BALLAST_MODE;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int hi_cnt = 0;
  int last_rise = 0;
  int rise_gap = 0;
  int hits, rnd;
  logic [15:0] exp_q[$];

  boost_pfc_ctrl #(.WD_CYCLES(WD)) dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
    .ZERO_CROSS_INPUT(ZERO_CROSS_INPUT), .BUS_OVER_CMP(BUS_OVER_CMP),
    .BUS_BELOW_REG_CMP(BUS_BELOW_REG_CMP), .BUS_UNDER_CMP(BUS_UNDER_CMP),
    .LINE_NEAR_ZERO(LINE_NEAR_ZERO), .BALLAST_MODE(BALLAST_MODE),
    .BOOST_GATE_OUT(BOOST_GATE_OUT), .GAIN_SEL_HIGH(GAIN_SEL_HIGH),
    .SUPPLY_DISCHARGE(SUPPLY_DISCHARGE), .COMP_VALUE(COMP_VALUE));

  boost_stage_model stage (.clk(SYS_CLK), .gate(BOOST_GATE_OUT), .stuck(stuck),
    .zx(ZERO_CROSS_INPUT));

  // 25 MHz clock
  always #20 SYS_CLK = ~SYS_CLK;

  // ************************************************************
  // Checking helpers
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task automatic finish_test;
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wait_gate(input logic v, input int lim);
    int n;
    n = 0;
    while (BOOST_GATE_OUT !== v && n < lim) begin
      @(negedge SYS_CLK);
      n++;
    end
    if (n >= lim) check(16'(BOOST_GATE_OUT), 16'(v));
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      wait_gate(1'b1, 400);
      wait_gate(1'b0, 400);
    end
  endtask

  // Counts cycles with the gate not low
  task automatic quiet(input int n);
    hits = 0;
    repeat (n) begin
      @(negedge SYS_CLK);
      if (BOOST_GATE_OUT !== 1'b0) hits++;
    end
  endtask

  // Loop model: on each turn-on, notes the width due from the inputs of the turn-on edge
  always @(posedge SYS_CLK) begin
    cyc++;
    if (RST_N !== 1'b1) begin
      comp_m = `COMP_RESET;
      gain_m = 1'b1;
      gain_d = 1'b1;
      gate_d = 1'b0;
      line_d = 1'b0;
      below_d = 1'b0;
      exp_q.delete();
    end else begin
      if (BOOST_GATE_OUT === 1'b1 && !gate_d) begin
        exp_q.push_back(16'(comp_m) + (line_d ? 16'(`MOD_CYCLES) : 16'h0000));
        step_m = gain_d ? `STEP_HI : `STEP_LO;
        comp_m = below_d ? comp_m + step_m : comp_m - step_m;
        rise_gap = cyc - last_rise;
        last_rise = cyc;
      end
      gate_d = (BOOST_GATE_OUT === 1'b1);
      line_d = LINE_NEAR_ZERO;
      below_d = BUS_BELOW_REG_CMP;
      // Gain select is registered, so it trails the mode by one enabled edge
      if (CLK_EN === 1'b1) begin
        gain_d = gain_m;
        gain_m = (BALLAST_MODE != BM_RUN);
      end
    end
  end

  // Monitor: counts the enabled cycles of each pulse and compares on turn-off, except for pulses cut by protection
  always @(posedge SYS_CLK) begin
    if (RST_N !== 1'b1) begin
      hi_cnt = 0;
      cut = 1'b0;
    end else if (BOOST_GATE_OUT === 1'b1) begin
      if (CLK_EN === 1'b1) hi_cnt++;
      if (BUS_OVER_CMP || BUS_UNDER_CMP || BALLAST_MODE == BM_FAULT) cut = 1'b1;
    end else if (hi_cnt != 0) begin
      if (!cut) check(16'(hi_cnt), exp_q[0]);
      void'(exp_q.pop_front());
      hi_cnt = 0;
      cut = 1'b0;
    end
  end

  // Run limit well above the expected length of the sequence
  initial begin
    #(40 * 60000);
    bad_count++;
    finish_test();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rnd = $urandom(26);
    RST_N = 1'b0;
    CLK_EN = 1'b1;
    BUS_OVER_CMP = 1'b0;
    BUS_BELOW_REG_CMP = 1'b1;
    BUS_UNDER_CMP = 1'b0;
    LINE_NEAR_ZERO = 1'b0;
    BALLAST_MODE = BM_PREHEAT;
    stuck = 1'b0;
    repeat (5) @(negedge SYS_CLK);
    check(16'(BOOST_GATE_OUT), 16'h0);
    check(16'(GAIN_SEL_HIGH), 16'h1);
    check(16'(SUPPLY_DISCHARGE), 16'h0);
    check(16'(COMP_VALUE), 16'(`COMP_RESET));
    RST_N = 1'b1;
    // First turn-on is a restart pulse, then zero-cross driven cycles
    wait_gate(1'b1, WD + 10);
    pulses(4);
    check(16'(COMP_VALUE), 16'(comp_m));
    // Modulation near line zero, random loop direction
    LINE_NEAR_ZERO = 1'b1;
    BUS_BELOW_REG_CMP = 1'($urandom % 2);
    pulses(4);
    LINE_NEAR_ZERO = 1'b0;
    // Run mode: low gain, bus high shortens on-time
    BALLAST_MODE = BM_RUN;
    BUS_BELOW_REG_CMP = 1'b0;
    repeat (2) @(negedge SYS_CLK);
    check(16'(GAIN_SEL_HIGH), 16'h0);
    pulses(4);
    check(16'(COMP_VALUE), 16'(comp_m));
    // Clock enable low freezes a pulse in mid-flight; its width counts enabled cycles only
    wait_gate(1'b1, 400);
    repeat (3) @(negedge SYS_CLK);
    CLK_EN = 1'b0;
    repeat (10) @(negedge SYS_CLK);
    check(16'(BOOST_GATE_OUT), 16'h1);
    check(16'(COMP_VALUE), 16'(comp_m));
    CLK_EN = 1'b1;
    wait_gate(1'b0, 400);
    // Missing zero-cross: restart pulses at a fixed period
    stuck = 1'b1;
    pulses(2);
    for (int i = 0; i < 3; i++) begin
      pulses(1);
      check(16'(rise_gap), 16'(WD));
    end
    stuck = 1'b0;
    pulses(3);
    // Over-voltage in mid pulse, then one pulse on recovery
    BUS_BELOW_REG_CMP = 1'b1;
    wait_gate(1'b1, 400);
    repeat (5) @(negedge SYS_CLK);
    BUS_OVER_CMP = 1'b1;
    @(negedge SYS_CLK);
    check(16'(BOOST_GATE_OUT), 16'h0);
    quiet(300);
    check(16'(hits), 16'h0);
    BUS_OVER_CMP = 1'b0;
    wait_gate(1'b1, 3);
    pulses(3);
    // Ballast fault stops switching; run mode resumes it
    wait_gate(1'b1, 400);
    repeat (3) @(negedge SYS_CLK);
    BALLAST_MODE = BM_FAULT;
    @(negedge SYS_CLK);
    check(16'(BOOST_GATE_OUT), 16'h0);
    quiet(300);
    check(16'(hits), 16'h0);
    check(16'(GAIN_SEL_HIGH), 16'h1);
    BALLAST_MODE = BM_RUN;
    pulses(2);
    // Under-voltage latches the gate low and supply discharge high until reset
    wait_gate(1'b1, 400);
    repeat (3) @(negedge SYS_CLK);
    BUS_UNDER_CMP = 1'b1;
    @(negedge SYS_CLK);
    check(16'(SUPPLY_DISCHARGE), 16'h1);
    check(16'(BOOST_GATE_OUT), 16'h0);
    BUS_UNDER_CMP = 1'b0;
    quiet(300);
    check(16'(hits), 16'h0);
    check(16'(SUPPLY_DISCHARGE), 16'h1);
    RST_N = 1'b0;
    repeat (2) @(negedge SYS_CLK);
    check(16'(SUPPLY_DISCHARGE), 16'h0);
    check(16'(BOOST_GATE_OUT), 16'h0);
    check(16'(GAIN_SEL_HIGH), 16'h1);
    check(16'(COMP_VALUE), 16'(`COMP_RESET));
    // Release in mid-run: gate stays low, then a restart pulse and normal cycles
    RST_N = 1'b1;
    @(negedge SYS_CLK);
    check(16'(BOOST_GATE_OUT), 16'h0);
    check(16'(GAIN_SEL_HIGH), 16'h0);
    pulses(3);
    check(16'(COMP_VALUE), 16'(comp_m));
    finish_test();
  end
endmodule
